// ==== verilog/scmc_pkg.sv ====
// shared constants, types and helpers for the system clock mode control block
package scmc_pkg;

	// ****************************************************************
	// register map (byte addresses on the wishbone slave)
	// ****************************************************************
	localparam logic [3:0] ADR_MODE = 4'h0;
	localparam logic [3:0] ADR_CTRL = 4'h4;

	// reset values of the two registers
	localparam logic [7:0] MODE_RST = 8'h03;
	localparam logic [7:0] CTRL_RST = 8'h00;

	// clock_mode_select field positions
	localparam int B_HL = 0;
	localparam int B_IDLE = 1;
	localparam int B_HTO = 2;
	localparam int B_LTO = 3;
	localparam int B_FST = 4;
	localparam int B_CKS = 5;

	// system_control_flags field positions
	localparam int B_WRF = 0;
	localparam int B_LRF = 1;
	localparam int B_LOW_VOLTAGE_RESET_FLAG = 2;
	localparam int B_FSYS = 7;

	// divider codes whose upper two bits are zero pick the substitute clock
	localparam logic [1:0] CKS_SUB_TOP = 2'h0;

	// ****************************************************************
	// oscillator settle counts, in cycles of the oscillator itself
	// ****************************************************************
	localparam logic [7:0] HTO_XTAL_CYC = 8'h80;
	localparam logic [7:0] HTO_INTERNAL_FAST_RC_CYC = 8'h10;
	localparam logic [7:0] LTO_CYC = 8'h02;

	// operating modes, gray coded along run -> idle -> sleep
	typedef enum logic [2:0] {
		SCMC_NORMAL = 3'h0,
		SCMC_SLOW = 3'h1,
		SCMC_IDLE_CLOCK_ON_MODE = 3'h3,
		SCMC_IDLE_CLOCK_OFF_MODE = 3'h2,
		SCMC_LIGHT_SLEEP_MODE = 3'h6,
		SCMC_DEEP_SLEEP_MODE = 3'h7
	} scmc_mode_e;

	// classic wishbone request from the master
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [3:0] adr;
		logic [31:0] dat;
	} scmc_wb_req_s;

	// tap mask on the divider counter: one tick out per 2**n ticks in
	function automatic logic [5:0] scmc_div_mask(input logic [2:0] code);
		case (code)
			3'h2: scmc_div_mask = 6'h3F;
			3'h3: scmc_div_mask = 6'h1F;
			3'h4: scmc_div_mask = 6'h0F;
			3'h5: scmc_div_mask = 6'h07;
			3'h6: scmc_div_mask = 6'h03;
			default: scmc_div_mask = 6'h01;
		endcase
	endfunction

endpackage

// ==== verilog/scmc_divider.sv ====
// prescaler for the high speed clock ticks, divide by 2 to 64
`timescale 1ns/100ps
module scmc_divider (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic tick_i,
	input wire logic [2:0] code_i,
	output logic div_tick_o
);
	logic [5:0] cnt_r;
	logic [5:0] mask_w;

	// the counter free-runs on input ticks, so a code change takes effect at once
	assign mask_w = scmc_pkg::scmc_div_mask(code_i);
	assign div_tick_o = tick_i & ((cnt_r & mask_w) == mask_w);

	// count high speed ticks
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_r <= 6'h00;
		end else if (tick_i) begin
			cnt_r <= cnt_r + 6'h01;
		end
	end
endmodule // scmc_divider

// ==== verilog/scmc_ready_cnt.sv ====
// oscillator settle counter: ready after a set number of ticks while enabled
`timescale 1ns/100ps
module scmc_ready_cnt (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic en_i,
	input wire logic tick_i,
	input wire logic [7:0] limit_i,
	output logic ready_o
);
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;

	assign cnt_nxt = cnt_r + 8'h01;

	// a stopped oscillator loses its ready state and must settle again
	always_ff @(posedge clk_i) begin
		if (rst_i || !en_i) begin
			cnt_r <= 8'h00;
			ready_o <= 1'b0;
		end else if (tick_i && !ready_o) begin
			cnt_r <= cnt_nxt;
			ready_o <= (cnt_nxt >= limit_i);
		end
	end
endmodule // scmc_ready_cnt

// ==== verilog/scmc_top.sv ====
// system clock and operating mode control with reset-cause flags
`timescale 1ns/100ps

// Contract
// - high/low select 1 runs undivided high clock
// - codes 000/001 substitute, 010..110 divide 64..4
// - moving to substitute clock stops high oscillator
// - normal mode: high clock divided 1 to 64
// - slow mode: slow RC clock, high clock off
// - halt with idle disabled enters sleep
// - deep sleep stops substitute, watchdog; refused with detect
// - light sleep keeps substitute clock for detect/watchdog
// - idle clock off: system oscillator stopped, substitute runs
// - idle clock on: oscillators keep running, CPU stopped
// - fast wake runs substitute clock, crystal only
// - low ready zero in deep sleep, two ticks
// - high ready cleared at reset, low when stopped
// - high ready after 128 crystal or 16 RC ticks
// - low voltage reset flag, cleared by writing zero
// - bad voltage setting flag plus software reset
// - watchdog control reset flag, cleared by zero write
// - control bits 6 to 3 read zero
// - substitute clock from slow RC to timers
// - fast wake: substitute clock until crystal ready
module scmc_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire scmc_pkg::scmc_wb_req_s wb_i,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	input wire logic hs_tick_i,
	input wire logic internal_slow_rc_tick_i,
	input wire logic hs_is_crystal_i,
	input wire logic halt_i,
	input wire logic wake_i,
	input wire logic wdt_enable_i,
	input wire logic low_voltage_detect_enable_i,
	input wire logic lvr_event_i,
	input wire logic low_voltage_reset_config_invalid_i,
	input wire logic wdt_ctrl_reset_i,
	output logic sys_tick_o,
	output logic cpu_run_o,
	output logic hs_osc_en_o,
	output logic sub_osc_en_o,
	output logic sub_tick_o,
	output logic wdt_stop_o,
	output logic soft_reset_o,
	output scmc_pkg::scmc_mode_e mode_o
);
	// ****************************************************************
	// registers and state
	// ****************************************************************
	logic [7:0] mode_sel_r;
	logic [7:0] ctrl_r;
	logic [7:0] ctrl_nxt;
	logic fast_r;
	logic fast_nxt;
	logic low_voltage_reset_config_bad_d_r;
	scmc_pkg::scmc_mode_e state_r;
	scmc_pkg::scmc_mode_e state_nxt;

	// wishbone decode
	logic wb_req_w;
	logic wr_w;
	logic hit_mode_w;
	logic hit_ctrl_w;
	logic wr_mode_w;
	logic wr_ctrl_w;
	logic [7:0] rd_byte_w;
	logic [7:0] mode_rd_w;

	// clock selection
	logic hl_w;
	logic [2:0] cks_w;
	logic sel_sub_w;
	logic div_tick_w;
	logic sys_tick_nxt;
	logic running_w;
	logic hs_en_nxt;
	logic sub_en_nxt;
	logic hto_w;
	logic lto_w;
	logic [7:0] hto_lim_w;
	logic src_ready_w;
	logic osc_off_w;

	// ****************************************************************
	// wishbone slave: one wait state, ack for one cycle
	// ****************************************************************
	assign wb_req_w = wb_i.cyc & wb_i.stb & ~wb_ack_o;
	assign wr_w = wb_req_w & wb_i.we & wb_i.sel[0];
	assign hit_mode_w = (wb_i.adr == scmc_pkg::ADR_MODE);
	assign hit_ctrl_w = (wb_i.adr == scmc_pkg::ADR_CTRL);
	assign wr_mode_w = wr_w & hit_mode_w;
	assign wr_ctrl_w = wr_w & hit_ctrl_w;

	// read view of the mode register with the two live ready flags
	always_comb begin
		mode_rd_w = mode_sel_r;
		mode_rd_w[scmc_pkg::B_HTO] = hto_w;
		mode_rd_w[scmc_pkg::B_LTO] = lto_w;
	end

	// unmapped addresses answer with zero and drop writes
	assign rd_byte_w = hit_mode_w ? mode_rd_w :
		hit_ctrl_w ? ctrl_r : 8'h00;

	// ack and read data
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wb_req_w;
			wb_dat_o <= wb_req_w ? {24'h000000, rd_byte_w} : 32'h00000000;
		end
	end

	// clock_mode_select: ready flags are read only and not stored
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_sel_r <= scmc_pkg::MODE_RST;
		end else if (wr_mode_w) begin
			mode_sel_r <= wb_i.dat[7:0] & 8'hF3;
		end
	end

	// ****************************************************************
	// system_control_flags: sticky reset causes
	// ****************************************************************
	// a zero write clears, a one write keeps; a set in the same cycle wins
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (wr_ctrl_w) begin
			ctrl_nxt[scmc_pkg::B_FSYS] = wb_i.dat[scmc_pkg::B_FSYS];
			ctrl_nxt[scmc_pkg::B_LOW_VOLTAGE_RESET_FLAG] = ctrl_r[scmc_pkg::B_LOW_VOLTAGE_RESET_FLAG] & wb_i.dat[scmc_pkg::B_LOW_VOLTAGE_RESET_FLAG];
			ctrl_nxt[scmc_pkg::B_LRF] = ctrl_r[scmc_pkg::B_LRF] & wb_i.dat[scmc_pkg::B_LRF];
			ctrl_nxt[scmc_pkg::B_WRF] = ctrl_r[scmc_pkg::B_WRF] & wb_i.dat[scmc_pkg::B_WRF];
		end
		if (lvr_event_i) begin
			ctrl_nxt[scmc_pkg::B_LOW_VOLTAGE_RESET_FLAG] = 1'b1;
		end
		if (low_voltage_reset_config_invalid_i) begin
			ctrl_nxt[scmc_pkg::B_LRF] = 1'b1;
		end
		if (wdt_ctrl_reset_i) begin
			ctrl_nxt[scmc_pkg::B_WRF] = 1'b1;
		end
		ctrl_nxt[6:3] = 4'h0;
	end

	// flags survive anything but a zero write or a reset of this block, which clears them
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r <= scmc_pkg::CTRL_RST;
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	// an undefined voltage setting acts as a software reset, once per onset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			low_voltage_reset_config_bad_d_r <= 1'b0;
			soft_reset_o <= 1'b0;
		end else begin
			low_voltage_reset_config_bad_d_r <= low_voltage_reset_config_invalid_i;
			soft_reset_o <= low_voltage_reset_config_invalid_i & ~low_voltage_reset_config_bad_d_r;
		end
	end

	// ****************************************************************
	// clock source selection
	// ****************************************************************
	assign hl_w = mode_sel_r[scmc_pkg::B_HL];
	assign cks_w = mode_sel_r[7:scmc_pkg::B_CKS];
	assign sel_sub_w = ~hl_w & (cks_w[2:1] == scmc_pkg::CKS_SUB_TOP);

	scmc_divider u_div (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_i(hs_tick_i),
		.code_i(cks_w),
		.div_tick_o(div_tick_w)
	);

	// fast wake borrows the substitute clock until the crystal settles
	always_comb begin
		if (fast_r) begin
			sys_tick_nxt = internal_slow_rc_tick_i;
		end else if (hl_w) begin
			sys_tick_nxt = hs_tick_i;
		end else if (sel_sub_w) begin
			sys_tick_nxt = internal_slow_rc_tick_i;
		end else begin
			sys_tick_nxt = div_tick_w;
		end
	end

	assign running_w = (state_r == scmc_pkg::SCMC_NORMAL) | (state_r == scmc_pkg::SCMC_SLOW);
	assign osc_off_w = (state_r == scmc_pkg::SCMC_DEEP_SLEEP_MODE) | (state_r == scmc_pkg::SCMC_LIGHT_SLEEP_MODE) |
		(state_r == scmc_pkg::SCMC_IDLE_CLOCK_OFF_MODE);

	// high oscillator runs only when a running or idle-on mode needs it
	assign hs_en_nxt = ~sel_sub_w & (running_w | (state_r == scmc_pkg::SCMC_IDLE_CLOCK_ON_MODE));
	// substitute oscillator stops only in deep sleep
	assign sub_en_nxt = (state_r != scmc_pkg::SCMC_DEEP_SLEEP_MODE);

	// ****************************************************************
	// oscillator ready flags
	// ****************************************************************
	assign hto_lim_w = hs_is_crystal_i ? scmc_pkg::HTO_XTAL_CYC : scmc_pkg::HTO_INTERNAL_FAST_RC_CYC;

	scmc_ready_cnt u_hto (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.en_i(hs_osc_en_o),
		.tick_i(hs_tick_i),
		.limit_i(hto_lim_w),
		.ready_o(hto_w)
	);

	scmc_ready_cnt u_lto (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.en_i(sub_osc_en_o),
		.tick_i(internal_slow_rc_tick_i),
		.limit_i(scmc_pkg::LTO_CYC),
		.ready_o(lto_w)
	);

	// the CPU waits for its source unless fast wake covers the gap
	assign src_ready_w = fast_r | ((sel_sub_w & ~hl_w) ? lto_w : hto_w);

	// ****************************************************************
	// operating mode state machine
	// ****************************************************************
	always_comb begin
		state_nxt = state_r;
		fast_nxt = fast_r & ~hto_w;
		case (state_r)
			scmc_pkg::SCMC_NORMAL, scmc_pkg::SCMC_SLOW: begin
				if (halt_i) begin
					if (mode_sel_r[scmc_pkg::B_IDLE]) begin
						state_nxt = ctrl_r[scmc_pkg::B_FSYS] ? scmc_pkg::SCMC_IDLE_CLOCK_ON_MODE :
							scmc_pkg::SCMC_IDLE_CLOCK_OFF_MODE;
					end else if (wdt_enable_i || low_voltage_detect_enable_i) begin
						state_nxt = scmc_pkg::SCMC_LIGHT_SLEEP_MODE;
					end else begin
						state_nxt = scmc_pkg::SCMC_DEEP_SLEEP_MODE;
					end
				end else begin
					state_nxt = sel_sub_w ? scmc_pkg::SCMC_SLOW : scmc_pkg::SCMC_NORMAL;
				end
			end
			default: begin
				if (wake_i) begin
					state_nxt = sel_sub_w ? scmc_pkg::SCMC_SLOW : scmc_pkg::SCMC_NORMAL;
					// only the crystal path and a live substitute clock allow it
					fast_nxt = mode_sel_r[scmc_pkg::B_FST] & hs_is_crystal_i & ~sel_sub_w &
						((state_r == scmc_pkg::SCMC_LIGHT_SLEEP_MODE) |
						(state_r == scmc_pkg::SCMC_IDLE_CLOCK_OFF_MODE));
				end
			end
		endcase
	end

	// state and fast wake hold
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= scmc_pkg::SCMC_NORMAL;
			fast_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			fast_r <= fast_nxt;
		end
	end

	// ****************************************************************
	// registered outputs
	// ****************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sys_tick_o <= 1'b0;
			cpu_run_o <= 1'b0;
			hs_osc_en_o <= 1'b0;
			sub_osc_en_o <= 1'b0;
			sub_tick_o <= 1'b0;
			wdt_stop_o <= 1'b0;
			mode_o <= scmc_pkg::SCMC_NORMAL;
		end else begin
			sys_tick_o <= sys_tick_nxt & (running_w | (state_r == scmc_pkg::SCMC_IDLE_CLOCK_ON_MODE));
			cpu_run_o <= running_w & src_ready_w & ~halt_i;
			hs_osc_en_o <= hs_en_nxt;
			sub_osc_en_o <= sub_en_nxt;
			sub_tick_o <= internal_slow_rc_tick_i & sub_en_nxt;
			wdt_stop_o <= (state_r == scmc_pkg::SCMC_DEEP_SLEEP_MODE);
			mode_o <= state_r;
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	property p_hl_undivided;
		@(posedge clk_i) disable iff (rst_i)
		(hl_w && !fast_r && running_w) |=> (sys_tick_o == $past(hs_tick_i));
	endproperty
	a_hl_undivided: assert property (p_hl_undivided) else $error("undivided clock not passed");

	property p_sub_stops_hs;
		@(posedge clk_i) disable iff (rst_i)
		(running_w && sel_sub_w) |=> !hs_osc_en_o;
	endproperty
	a_sub_stops_hs: assert property (p_sub_stops_hs) else $error("high osc runs on substitute");

	property p_halt_sleep;
		@(posedge clk_i) disable iff (rst_i)
		(running_w && halt_i && !mode_sel_r[scmc_pkg::B_IDLE]) |=>
			(state_r == scmc_pkg::SCMC_DEEP_SLEEP_MODE || state_r == scmc_pkg::SCMC_LIGHT_SLEEP_MODE) ##1 !cpu_run_o;
	endproperty
	a_halt_sleep: assert property (p_halt_sleep) else $error("halt did not sleep");

	property p_no_deep_with_lvd;
		@(posedge clk_i) disable iff (rst_i)
		(running_w && halt_i && low_voltage_detect_enable_i) |=> (state_r != scmc_pkg::SCMC_DEEP_SLEEP_MODE);
	endproperty
	a_no_deep_with_lvd: assert property (p_no_deep_with_lvd) else $error("deep sleep with detect");

	property p_deep_sub_off;
		@(posedge clk_i) disable iff (rst_i)
		(state_r == scmc_pkg::SCMC_DEEP_SLEEP_MODE) |=> (!sub_osc_en_o && wdt_stop_o && !sub_tick_o);
	endproperty
	a_deep_sub_off: assert property (p_deep_sub_off) else $error("substitute runs in deep sleep");

	property p_idle_clock_off_mode_entry;
		@(posedge clk_i) disable iff (rst_i)
		(running_w && halt_i && mode_sel_r[scmc_pkg::B_IDLE] && !ctrl_r[scmc_pkg::B_FSYS]) |=>
			(state_r == scmc_pkg::SCMC_IDLE_CLOCK_OFF_MODE) ##1 (!hs_osc_en_o && sub_osc_en_o);
	endproperty
	a_idle_clock_off_mode_entry: assert property (p_idle_clock_off_mode_entry) else $error("idle clock off wrong");

	property p_idle_clock_on_mode_entry;
		@(posedge clk_i) disable iff (rst_i)
		(running_w && halt_i && mode_sel_r[scmc_pkg::B_IDLE] && ctrl_r[scmc_pkg::B_FSYS]) |=>
			(state_r == scmc_pkg::SCMC_IDLE_CLOCK_ON_MODE) ##1 sub_osc_en_o;
	endproperty
	a_idle_clock_on_mode_entry: assert property (p_idle_clock_on_mode_entry) else $error("idle clock on wrong");

	property p_hto_low_off;
		@(posedge clk_i) disable iff (rst_i)
		(osc_off_w [*3]) |-> !hto_w;
	endproperty
	a_hto_low_off: assert property (p_hto_low_off) else $error("high ready while stopped");

	property p_low_voltage_reset_flag_set;
		@(posedge clk_i) disable iff (rst_i)
		lvr_event_i |=> ctrl_r[scmc_pkg::B_LOW_VOLTAGE_RESET_FLAG];
	endproperty
	a_low_voltage_reset_flag_set: assert property (p_low_voltage_reset_flag_set) else $error("voltage reset flag not set");

	property p_ctrl_gap_zero;
		@(posedge clk_i) disable iff (rst_i)
		(wb_req_w && hit_ctrl_w && !wb_i.we) |=> (wb_ack_o && wb_dat_o[6:3] == 4'h0);
	endproperty
	a_ctrl_gap_zero: assert property (p_ctrl_gap_zero) else $error("unused bits not zero");
endmodule // scmc_top

// ==== tb/tb_top.sv ====
// self-checking bench for the system clock mode control block
`timescale 1ns/100ps
module tb_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	scmc_pkg::scmc_wb_req_s wb_i = '0;
	logic hs_tick_i = 1'b1;
	logic [2:0] internal_slow_rc_cnt_r = 3'h0;
	logic internal_slow_rc_tick_i;
	logic hs_is_crystal_i = 1'b0;
	logic halt_i = 1'b0;
	logic wake_i = 1'b0;
	logic wdt_enable_i = 1'b0;
	logic low_voltage_detect_enable_i = 1'b0;
	logic lvr_event_i = 1'b0;
	logic low_voltage_reset_config_invalid_i = 1'b0;
	logic wdt_ctrl_reset_i = 1'b0;
	logic wb_ack_o, sys_tick_o, cpu_run_o, hs_osc_en_o, sub_osc_en_o, sub_tick_o;
	logic wdt_stop_o, soft_reset_o;
	logic [31:0] wb_dat_o;
	scmc_pkg::scmc_mode_e mode_o;
	int err_count = 0;
	int checks_done = 0;
	localparam logic [3:0] MD = scmc_pkg::ADR_MODE;
	localparam logic [3:0] CT = scmc_pkg::ADR_CTRL;

	scmc_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_ack_o(wb_ack_o),
		.wb_dat_o(wb_dat_o), .hs_tick_i(hs_tick_i), .internal_slow_rc_tick_i(internal_slow_rc_tick_i),
		.hs_is_crystal_i(hs_is_crystal_i), .halt_i(halt_i), .wake_i(wake_i),
		.wdt_enable_i(wdt_enable_i), .low_voltage_detect_enable_i(low_voltage_detect_enable_i),
		.lvr_event_i(lvr_event_i), .low_voltage_reset_config_invalid_i(low_voltage_reset_config_invalid_i),
		.wdt_ctrl_reset_i(wdt_ctrl_reset_i), .sys_tick_o(sys_tick_o), .cpu_run_o(cpu_run_o),
		.hs_osc_en_o(hs_osc_en_o), .sub_osc_en_o(sub_osc_en_o), .sub_tick_o(sub_tick_o),
		.wdt_stop_o(wdt_stop_o), .soft_reset_o(soft_reset_o), .mode_o(mode_o));

	// 20 MHz clock; slow rc ticks once every 8 cycles so it is clearly slower
	always #25 clk_i = ~clk_i;
	always @(posedge clk_i) internal_slow_rc_cnt_r <= internal_slow_rc_cnt_r + 3'h1;
	assign internal_slow_rc_tick_i = (internal_slow_rc_cnt_r == 3'h7);

	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic rng(input int v, input int lo, input int hi);
		chk({31'h0, (v >= lo && v <= hi)}, 32'h1);
	endtask

	task automatic ran_out;
		err_count++;
		$display("BAD t=%0t wait ran out", $time);
		end_sim();
	endtask

	// classic single cycle: hold the request until ack is sampled high
	task automatic bus(input logic we, input logic [3:0] a, input logic [7:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: a, dat: {24'h0, d}};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20) ran_out();
		q = wb_dat_o;
		wb_i <= '0;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	// read and compare the bits under the mask; unmasked bits are not judged
	task automatic rdc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(q & m, e);
	endtask

	task automatic ticks(input int cyc, output int c);
		c = 0;
		repeat (cyc) begin
			@(posedge clk_i);
			c += (sys_tick_o === 1'b1);
		end
	endtask

	task automatic halt_now;
		@(posedge clk_i) halt_i <= 1'b1;
		@(posedge clk_i) halt_i <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask

	// cycles from the wake pulse until the cpu may run again, bounded
	task automatic wake_now(output int n);
		@(posedge clk_i) wake_i <= 1'b1;
		@(posedge clk_i) wake_i <= 1'b0;
		n = 0;
		while (cpu_run_o !== 1'b1 && n < 400) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 400) ran_out();
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_regs;
		rdc(MD, 32'hFFFF_FFF3, 32'h03);
		rdc(CT, 32'hFFFF_FFFF, 32'h00);
		repeat (40) @(posedge clk_i);
		rdc(MD, 32'h04, 32'h04);
		wr(CT, 8'hFF);
		rdc(CT, 32'hFFFF_FFFF, 32'h80);
		wr(4'h8, 8'hFF);
		rdc(4'h8, 32'hFFFF_FFFF, 32'h00);
		wr(CT, 8'h00);
	endtask

	task automatic t_flags;
		int c;
		@(posedge clk_i) lvr_event_i <= 1'b1;
		@(posedge clk_i) lvr_event_i <= 1'b0;
		wdt_ctrl_reset_i <= 1'b1;
		low_voltage_reset_config_invalid_i <= 1'b1;
		@(posedge clk_i) wdt_ctrl_reset_i <= 1'b0;
		c = 0;
		repeat (6) begin
			@(posedge clk_i);
			c += (soft_reset_o === 1'b1);
		end
		low_voltage_reset_config_invalid_i <= 1'b0;
		chk(c, 1);
		rdc(CT, 32'hFF, 32'h07);
		wr(CT, 8'h05);
		rdc(CT, 32'hFF, 32'h05);
		wr(CT, 8'h00);
		rdc(CT, 32'hFF, 32'h00);
	endtask

	// codes 0..7 with the select bit low, then 8 stands for select bit high
	task automatic t_clk;
		int c;
		int e;
		for (int k = 0; k < 9; k++) begin
			wr(MD, (k == 8) ? 8'h01 : {k[2:0], 5'h00});
			repeat (60) @(posedge clk_i);
			e = (k < 2) ? 32 : ((k == 8) ? 256 : (256 >> (8 - k)));
			ticks(256, c);
			rng(c, e - 1, e + 1);
			if (k < 2) begin
				chk(mode_o, scmc_pkg::SCMC_SLOW);
				chk(hs_osc_en_o, 1'b0);
			end else begin
				chk(mode_o, scmc_pkg::SCMC_NORMAL);
			end
		end
	endtask

	// one row per halt choice: idle enable, clock in idle, watchdog, detect
	task automatic t_halt;
		scmc_pkg::scmc_mode_e ex [5] = '{scmc_pkg::SCMC_DEEP_SLEEP_MODE, scmc_pkg::SCMC_LIGHT_SLEEP_MODE,
			scmc_pkg::SCMC_LIGHT_SLEEP_MODE, scmc_pkg::SCMC_IDLE_CLOCK_OFF_MODE, scmc_pkg::SCMC_IDLE_CLOCK_ON_MODE};
		logic [3:0] cfg [5] = '{4'h0, 4'h2, 4'h1, 4'h8, 4'hC};
		int n;
		int c;
		for (int k = 0; k < 5; k++) begin
			wr(MD, {6'h00, cfg[k][3], 1'b1});
			wr(CT, {cfg[k][2], 7'h00});
			wdt_enable_i <= cfg[k][1];
			low_voltage_detect_enable_i <= cfg[k][0];
			halt_now();
			chk(mode_o, ex[k]);
			chk(cpu_run_o, 1'b0);
			chk(wdt_stop_o, k == 0);
			chk(sub_osc_en_o, k != 0);
			chk(hs_osc_en_o, k == 4);
			ticks(16, c);
			chk(c != 0, k == 4);
			// timers keep their substitute tick unless deep sleep stopped the slow rc
			c = 0;
			repeat (16) begin
				@(posedge clk_i);
				c += (sub_tick_o === 1'b1);
			end
			chk(c, (k != 0) ? 2 : 0);
			rdc(MD, 32'h0C, {(k != 0), (k == 4), 2'b00});
			wake_now(n);
			if (k == 4) rng(n, 0, 6);
			else rng(n, 14, 26);
			chk(mode_o, scmc_pkg::SCMC_NORMAL);
			repeat (20) @(posedge clk_i);
			rdc(MD, 32'h0C, 32'h0C);
		end
	endtask

	// crystal source: slow wake, then fast wake on the substitute clock
	task automatic t_xtal;
		int n;
		int c;
		hs_is_crystal_i <= 1'b1;
		wdt_enable_i <= 1'b1;
		low_voltage_detect_enable_i <= 1'b0;
		wr(MD, 8'h01);
		halt_now();
		wake_now(n);
		rng(n, 127, 140);
		wr(MD, 8'h11);
		halt_now();
		chk(mode_o, scmc_pkg::SCMC_LIGHT_SLEEP_MODE);
		wake_now(n);
		rng(n, 0, 20);
		rdc(MD, 32'h04, 32'h00);
		ticks(40, c);
		rng(c, 3, 6);
		repeat (160) @(posedge clk_i);
		rdc(MD, 32'h04, 32'h04);
		ticks(32, c);
		rng(c, 31, 32);
	endtask

	// ****************************************************************
	// main sequence and overall time limit
	// ****************************************************************
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_flags();
		t_clk();
		t_halt();
		t_xtal();
		end_sim();
	end

	initial begin
		#(50 * 60000);
		ran_out();
	end
endmodule // tb_top
